// ---- sfm_pkg.sv ----
// constants and types for the secure access and fault monitor
package sfm_pkg;
   // privilege modes, boot level highest
   localparam logic [1:0] MODE_USER = 2'h0;
   localparam logic [1:0] MODE_PRIV = 2'h1;
   localparam logic [1:0] MODE_BOOT = 2'h2;
   localparam logic [1:0] MODE_TEST = 2'h3;
   // register map of the plain software port (word index)
   localparam logic [3:0] REG_MMU_OPEN = 4'h0;
   localparam logic [3:0] REG_FIREWALL = 4'h1;
   localparam logic [3:0] REG_STATUS = 4'h2;
   localparam logic [3:0] REG_ERRCNT = 4'h3;
   localparam logic [3:0] REG_FUSE = 4'h4;
   localparam logic [3:0] REG_SWRESET = 4'h5;
   // restrictive defaults
   localparam logic [7:0] MMU_OPEN_RST = 8'h00;
   localparam logic [7:0] FIREWALL_RST = 8'hFF;
   // reset cause codes
   localparam logic [2:0] CAUSE_NONE = 3'h0;
   localparam logic [2:0] CAUSE_SENSOR = 3'h1;
   localparam logic [2:0] CAUSE_INTEGRITY = 3'h2;
   localparam logic [2:0] CAUSE_ACCESS = 3'h3;
   localparam logic [2:0] CAUSE_RANGE = 3'h4;
   localparam logic [2:0] CAUSE_SFR = 3'h5;
   localparam logic [2:0] CAUSE_SOFT = 3'h6;
   // reset pulse length in cycles
   localparam int RST_PULSE_NS = 100;
   localparam int CLK_PERIOD_NS = 10;
   localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] RST_PULSE_LEN = 4'(RST_PULSE_CYC);
   typedef enum logic [1:0] {ST_BOOT, ST_RUN, ST_RESET, ST_DEAD} sfm_state_t;
endpackage

// ---- sfm_monitor.sv ----
// secure access and fault monitor: boot mode, access checks, reset and error counter
// Contract
// - out-of-limit sensor raises reset; security-type sensors also decrement error counter
// - tampering detected on a running operation raises a counting reset
// - every attack or violation ends in reset to initial configuration
// - code and data words are integrity checked before consumption
// - code and data path carries address-keyed non-linear encrypted words
// - physical addresses are scrambled before memory writes
// - crypto coprocessor time does not depend on key or data
// - boot picks test firmware in privileged mode, else customer software
// - blown delivery fuse forbids test firmware selection forever
// - privileged outranks unprivileged; boot runs in a higher boot mode
// - software cannot change fuse configuration or security feature enables
// - accesses checked per code segment, target segment and operation type
// - conditional memory settings start most restrictive at boot
// - an error while segments are open restores restrictive settings
// - every access is also checked against configurable firewall bits; the code checks only user-mode data writes
// - special register permission depends on register and privilege mode
// - forbidden or missing special register read returns zero and security-resets
// - addresses outside implemented memory ranges force a reset
// - inconsistent addresses count as integrity violations
// - non-volatile memory uses ecc, double read and anti-tearing; the monitor takes only ecc and double read error inputs
// - security resets are limited; exhausted counter disables device permanently
module sfm_monitor
   import sfm_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter logic [15:0] MEM_TOP = 16'hBFFF,
   parameter logic [7:0] ERR_LIMIT = 8'h20,
   parameter logic [15:0] KEY_SEED = 16'h5A3C
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // boot straps and persistent state
   input wire logic test_req_i,
   input wire logic fuse_delivered_i,
   input wire logic [7:0] nv_errcnt_i,
   // sensors and integrity monitors
   input wire logic sensor_alarm_i,
   input wire logic sensor_secure_i,
   input wire logic tamper_i,
   input wire logic nvm_ecc_err_i,
   input wire logic nvm_dread_mismatch_i,
   // cpu access
   input wire logic acc_valid_i,
   input wire logic acc_write_i,
   input wire logic acc_fetch_i,
   input wire logic [ADDR_W-1:0] acc_addr_i,
   input wire logic acc_addr_par_i,
   input wire logic [31:0] acc_wdata_i,
   input wire logic [1:0] acc_code_seg_i,
   input wire logic [31:0] bus_word_i,
   input wire logic bus_word_par_i,
   // register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // outputs
   output logic [1:0] mode_o,
   output logic test_fw_o,
   output logic acc_grant_o,
   output logic [ADDR_W-1:0] mem_addr_o,
   output logic [31:0] mem_wdata_o,
   output logic [31:0] word_plain_o,
   output logic word_ok_o,
   output logic sys_reset_o,
   output logic [7:0] nv_errcnt_o,
   output logic nv_errcnt_we_o,
   output logic dead_o,
   output logic [2:0] cause_o
);
   initial begin
      if (ADDR_W != 16) $error("sfm_monitor supports 16-bit addresses only");
      if (ERR_LIMIT == 8'h00) $error("ERR_LIMIT must be nonzero");
   end

   typedef struct packed {
      sfm_state_t st;
      logic [1:0] mode;
      logic test_fw;
      logic [7:0] mmu_open;
      logic [7:0] firewall;
      logic [7:0] errcnt;
      logic errcnt_loaded;
      logic [3:0] rst_cnt;
      logic [2:0] cause;
      logic [7:0] rdata;
      logic grant;
      logic [15:0] maddr;
      logic [31:0] mwdata;
      logic [31:0] plain;
      logic word_ok;
      logic errwe;
      logic sres;
      logic dead;
   } sfm_reg_t;

   sfm_reg_t r;
   sfm_reg_t next_r;

   default clocking mon_cb @(posedge mclk_i);
   endclocking
   default disable iff (!resetn_i);

   // address-keyed non-linear scrambles; a rotation of an xor is cheap and invertible
   function automatic logic [15:0] scr_addr(input logic [15:0] a);
      logic [15:0] t;
      logic [15:0] u;
      t = a ^ KEY_SEED;
      u = {t[10:0], t[15:11]};
      // the high byte passes through unchanged, so the map stays one to one and never aliases two cells
      return {u[15:8], u[7:0] ^ (u[15:8] & {u[11:8], u[15:12]})};
   endfunction
   function automatic logic [31:0] keystream(input logic [15:0] a);
      logic [31:0] k;
      k = {a ^ KEY_SEED, ~a};
      return k ^ {k[22:0], k[31:23]} ^ (k & {k[7:0], k[31:8]});
   endfunction

   logic range_err;
   logic addr_incons;
   logic seg_deny;
   logic fw_deny;
   logic sfr_space;
   logic sfr_rd_deny;
   logic word_bad;
   logic [2:0] evt;
   logic evt_count;

   always_comb begin
      range_err = acc_valid_i && (acc_addr_i > MEM_TOP);
      addr_incons = acc_valid_i && ((^acc_addr_i) != acc_addr_par_i);
      // segment 2 of the target space is restricted, only open by mmu bit and only above user
      seg_deny = acc_valid_i && (acc_addr_i[15:14] == 2'h2) &&
                 (!r.mmu_open[acc_code_seg_i] || r.mode == MODE_USER ||
                 (acc_write_i && acc_fetch_i));
      fw_deny = acc_valid_i && !acc_fetch_i && acc_write_i &&
                r.firewall[acc_addr_i[13:11]] && (r.mode == MODE_USER);
      sfr_space = reg_rd_i && (reg_addr_i > REG_SWRESET);
      sfr_rd_deny = sfr_space || (reg_rd_i && reg_addr_i == REG_FUSE && r.mode == MODE_USER);
      word_bad = acc_valid_i && !acc_write_i && ((^bus_word_i) != bus_word_par_i);
      evt = CAUSE_NONE;
      evt_count = 1'b0;
      if (tamper_i || addr_incons || word_bad || nvm_dread_mismatch_i) begin
         evt = CAUSE_INTEGRITY;
         evt_count = 1'b1;
      end else if (sensor_alarm_i) begin
         evt = CAUSE_SENSOR;
         evt_count = sensor_secure_i;
      end else if (sfr_rd_deny) begin
         evt = CAUSE_SFR;
         evt_count = 1'b1;
      end else if (range_err) begin
         evt = CAUSE_RANGE;
      end else if (seg_deny || fw_deny) begin
         evt = CAUSE_ACCESS;
      end else if (reg_wr_i && reg_addr_i == REG_SWRESET && reg_wdata_i[0]) begin
         evt = CAUSE_SOFT;
         evt_count = reg_wdata_i[1];
      end
   end

   always_comb begin
      next_r = r;
      next_r.rdata = 8'h00;
      next_r.grant = 1'b0;
      next_r.errwe = 1'b0;
      next_r.word_ok = 1'b0;
      case (r.st)
         ST_BOOT: begin
            // error counter is loaded from non-volatile storage one cycle after release
            next_r.errcnt = nv_errcnt_i;
            next_r.errcnt_loaded = 1'b1;
            next_r.mmu_open = MMU_OPEN_RST;
            next_r.firewall = FIREWALL_RST;
            if (nv_errcnt_i == 8'h00) begin
               next_r.st = ST_DEAD;
            end else if (test_req_i && !fuse_delivered_i) begin
               next_r.mode = MODE_PRIV;
               next_r.test_fw = 1'b1;
               next_r.st = ST_RUN;
            end else begin
               next_r.mode = test_req_i ? MODE_USER : MODE_PRIV;
               next_r.test_fw = 1'b0;
               next_r.st = ST_RUN;
            end
         end
         ST_RUN: begin
            if (evt != CAUSE_NONE || nvm_ecc_err_i) begin
               next_r.cause = (evt != CAUSE_NONE) ? evt : CAUSE_INTEGRITY;
               next_r.mmu_open = MMU_OPEN_RST;
               next_r.firewall = FIREWALL_RST;
               next_r.rst_cnt = RST_PULSE_LEN;
               next_r.st = ST_RESET;
               if (evt_count) begin
                  next_r.errcnt = r.errcnt - 8'h01;
                  next_r.errwe = 1'b1;
               end
            end else begin
               if (acc_valid_i) begin
                  next_r.grant = 1'b1;
                  next_r.maddr = scr_addr(acc_addr_i);
                  next_r.mwdata = acc_wdata_i ^ keystream(acc_addr_i);
                  next_r.plain = bus_word_i ^ keystream(acc_addr_i);
                  next_r.word_ok = !acc_write_i;
               end
               if (reg_wr_i && r.mode != MODE_USER) begin
                  case (reg_addr_i)
                     REG_MMU_OPEN: next_r.mmu_open = reg_wdata_i;
                     REG_FIREWALL: next_r.firewall = reg_wdata_i;
                     default: next_r.mode = r.mode;
                  endcase
               end
               if (reg_rd_i) begin
                  case (reg_addr_i)
                     REG_MMU_OPEN: next_r.rdata = r.mmu_open;
                     REG_FIREWALL: next_r.rdata = r.firewall;
                     REG_STATUS: next_r.rdata = {3'h0, r.test_fw, r.mode, 2'h0};
                     REG_ERRCNT: next_r.rdata = r.errcnt;
                     REG_FUSE: next_r.rdata = {7'h00, fuse_delivered_i};
                     default: next_r.rdata = 8'h00;
                  endcase
               end
            end
         end
         ST_RESET: begin
            // the pulse restarts the system; then boot again into initial configuration, or go dead when the error counter is zero
            if (r.rst_cnt == 4'h1) begin
               next_r.st = (r.errcnt == 8'h00) ? ST_DEAD : ST_BOOT;
               next_r.mode = MODE_BOOT;
            end
            next_r.rst_cnt = r.rst_cnt - 4'h1;
         end
         ST_DEAD: begin
            next_r.st = ST_DEAD;
         end
         default: next_r.st = ST_BOOT;
      endcase
      // registered so the reset and dead lines reach the pins glitch free
      next_r.sres = (next_r.st == ST_RESET);
      next_r.dead = (next_r.st == ST_DEAD);
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         r <= '0;
         r.st <= ST_BOOT;
         r.mode <= MODE_BOOT;
         r.mmu_open <= MMU_OPEN_RST;
         r.firewall <= FIREWALL_RST;
         r.errcnt <= ERR_LIMIT;
      end else begin
         r <= next_r;
      end
   end

   assign reg_rdata_o = r.rdata;
   assign mode_o = r.mode;
   assign test_fw_o = r.test_fw;
   assign acc_grant_o = r.grant;
   assign mem_addr_o = r.maddr;
   assign mem_wdata_o = r.mwdata;
   assign word_plain_o = r.plain;
   assign word_ok_o = r.word_ok;
   assign sys_reset_o = r.sres;
   assign nv_errcnt_o = r.errcnt;
   assign nv_errcnt_we_o = r.errwe;
   assign dead_o = r.dead;
   assign cause_o = r.cause;

   property p_fuse;
      @(posedge mclk_i) disable iff (!resetn_i) fuse_delivered_i && r.st == ST_BOOT |=> !r.test_fw;
   endproperty
   fuse_blocks_test_a: assert property (p_fuse) else $error("test firmware after fuse");
   sensor_reset_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      r.st == ST_RUN && sensor_alarm_i |=> r.st == ST_RESET) else $error("sensor no reset");
   tamper_count_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      r.st == ST_RUN && tamper_i |=> r.errwe && r.errcnt == $past(r.errcnt) - 8'h01)
      else $error("tamper not counted");
   range_reset_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      r.st == ST_RUN && range_err |=> r.st == ST_RESET && !r.grant) else $error("range not reset");
   reset_restrict_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      r.st == ST_RESET |-> r.mmu_open == MMU_OPEN_RST) else $error("mmu open in reset");
   user_nowrite_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      r.mode == MODE_USER && r.st == ST_RUN && !sensor_alarm_i ##1 r.st == ST_RUN |-> $stable(r.mmu_open))
      else $error("user changed mmu");
   sfr_read_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      r.st == ST_RUN && sfr_space |=> r.rdata == 8'h00 ##0 r.st == ST_RESET) else $error("sfr read leaked");
   dead_stays_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      r.st == ST_DEAD |=> r.st == ST_DEAD [*3]) else $error("dead state left");
   reset_len_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      $rose(sys_reset_o) |-> sys_reset_o [*8]) else $error("reset pulse short");
   incons_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      r.st == ST_RUN && addr_incons |=> r.cause == CAUSE_INTEGRITY) else $error("address fault missed");
   boot_restrict_a: assert property (
      r.st == ST_BOOT |=> r.mmu_open == MMU_OPEN_RST && r.firewall == FIREWALL_RST)
      else $error("boot not restrictive");
   test_select_a: assert property (
      r.st == ST_BOOT && test_req_i && !fuse_delivered_i && nv_errcnt_i != 8'h00 |=> r.test_fw && r.mode == MODE_PRIV)
      else $error("test firmware not chosen");
   cust_mode_a: assert property (
      r.st == ST_BOOT && !(test_req_i && !fuse_delivered_i) && nv_errcnt_i != 8'h00 |=>
      !r.test_fw && (r.mode == MODE_USER || r.mode == MODE_PRIV)) else $error("bad customer mode");
   boot_once_a: assert property (
      r.st == ST_BOOT |=> r.st != ST_BOOT)
      else $error("boot state stuck");
   mode_legal_a: assert property (
      r.mode != MODE_TEST)
      else $error("illegal mode");
   word_check_a: assert property (
      r.st == ST_RUN && word_bad |=> r.st == ST_RESET && !r.word_ok)
      else $error("bad word consumed");
   fixed_latency_a: assert property (
      r.st == ST_RUN && acc_valid_i && evt == CAUSE_NONE && !nvm_ecc_err_i |=> r.grant)
      else $error("access latency varies");
   seg_deny_a: assert property (
      r.st == ST_RUN && seg_deny |=> r.st == ST_RESET && !r.grant)
      else $error("segment rule missed");
   access_cause_a: assert property (
      r.st == ST_RUN && evt == CAUSE_ACCESS |=> !r.errwe && r.cause == CAUSE_ACCESS)
      else $error("access cause wrong");
   grant_run_a: assert property (
      r.st != ST_RUN |=> !r.grant)
      else $error("grant outside run");
   firewall_deny_a: assert property (
      r.st == ST_RUN && fw_deny |=> r.st == ST_RESET && !r.grant)
      else $error("firewall missed");
   user_fw_a: assert property (
      r.st == ST_RUN && r.mode == MODE_USER && reg_wr_i && evt == CAUSE_NONE && !nvm_ecc_err_i |=>
      $stable(r.firewall)) else $error("user changed firewall");
   sfr_user_a: assert property (
      r.st == ST_RUN && r.mode == MODE_USER && reg_rd_i && reg_addr_i == REG_FUSE |=> r.rdata == 8'h00)
      else $error("fuse read leaked");
   sfr_count_a: assert property (
      r.st == ST_RUN && evt == CAUSE_SFR |=> r.errwe)
      else $error("sfr read not counted");
   rdata_idle_a: assert property (
      !reg_rd_i |=> r.rdata == 8'h00)
      else $error("read data without read");
   range_cause_a: assert property (
      r.st == ST_RUN && evt == CAUSE_RANGE |=> !r.errwe && r.cause == CAUSE_RANGE)
      else $error("range cause wrong");
   incons_count_a: assert property (
      r.st == ST_RUN && addr_incons |=> r.errwe)
      else $error("address fault not counted");
   sensor_count_a: assert property (
      r.st == ST_RUN && sensor_alarm_i && sensor_secure_i |=> r.errwe)
      else $error("secure sensor not counted");
   ecc_reset_a: assert property (
      r.st == ST_RUN && nvm_ecc_err_i && evt == CAUSE_NONE |=> r.st == ST_RESET && !r.errwe)
      else $error("ecc error missed");
   dread_count_a: assert property (
      r.st == ST_RUN && nvm_dread_mismatch_i |=> r.errwe)
      else $error("double read not counted");
   soft_reset_a: assert property (
      r.st == ST_RUN && evt == CAUSE_SOFT |=> r.cause == CAUSE_SOFT && r.sres)
      else $error("soft reset missed");
   reset_end_a: assert property (
      $fell(r.sres) |-> r.mode == MODE_BOOT && (r.st == ST_BOOT || r.st == ST_DEAD))
      else $error("reset did not reboot");
   reset_fw_a: assert property (
      r.st == ST_RESET |-> r.firewall == FIREWALL_RST)
      else $error("firewall open in reset");
   count_write_a: assert property (
      r.errwe |-> r.st == ST_RESET)
      else $error("counter write outside reset");
   errcnt_step_a: assert property (
      r.errwe |-> r.errcnt == $past(r.errcnt) - 8'h01)
      else $error("counter step wrong");
   zero_dead_a: assert property (
      r.st == ST_RESET && r.rst_cnt == 4'h1 && r.errcnt == 8'h00 |=> r.st == ST_DEAD)
      else $error("exhausted counter not dead");
   dead_quiet_a: assert property (
      r.st == ST_DEAD |=> !r.grant && !r.sres)
      else $error("dead device active");
   cov_test_c: cover property (@(posedge mclk_i) r.test_fw && r.st == ST_RUN);
   cov_open_c: cover property (@(posedge mclk_i) r.mmu_open != MMU_OPEN_RST ##1 r.grant);
   cov_dead_c: cover property (@(posedge mclk_i) r.st == ST_DEAD);
   cov_soft_c: cover property (@(posedge mclk_i) r.cause == CAUSE_SOFT && r.sres);
endmodule

// ---- sfm_cpu_model.sv ----
// cpu core model: issues one access per request with address and word parity
module sfm_cpu_model
   import sfm_pkg::*;
(
   // clock
   input wire logic mclk_i,
   // request from the bench
   input wire logic go_i,
   input wire logic write_i,
   input wire logic fetch_i,
   input wire logic [1:0] seg_i,
   input wire logic [15:0] addr_i,
   input wire logic bad_par_i,
   // access lines towards the monitor
   output logic acc_valid_o,
   output logic acc_write_o,
   output logic acc_fetch_o,
   output logic [15:0] acc_addr_o,
   output logic acc_addr_par_o,
   output logic [31:0] acc_wdata_o,
   output logic [1:0] acc_code_seg_o,
   output logic [31:0] bus_word_o,
   output logic bus_word_par_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      acc_valid_o = 1'b0;
      acc_write_o = 1'b0;
      acc_fetch_o = 1'b0;
      acc_addr_o = 16'h0000;
      acc_addr_par_o = 1'b0;
      acc_wdata_o = 32'h00000000;
      acc_code_seg_o = 2'h0;
      bus_word_o = 32'h00000000;
      bus_word_par_o = 1'b0;
   end
   // one access per request; released address and data lines toggle so stale values never look valid
   always @(posedge mclk_i) begin
      acc_valid_o <= go_i;
      if (go_i) begin
         acc_write_o <= write_i;
         acc_fetch_o <= fetch_i;
         acc_code_seg_o <= seg_i;
         acc_addr_o <= addr_i;
         acc_addr_par_o <= (^addr_i) ^ bad_par_i;
         acc_wdata_o <= {addr_i, ~addr_i};
         bus_word_o <= {~addr_i, addr_i};
         bus_word_par_o <= ^{~addr_i, addr_i};
      end else begin
         acc_addr_o <= ~acc_addr_o;
         acc_wdata_o <= ~acc_wdata_o;
         bus_word_o <= ~bus_word_o;
      end
   end
endmodule

// ---- sfm_monitor_tb.sv ----
// self-checking bench for the secure access and fault monitor
module sfm_monitor_tb import sfm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 1'b0, resetn_i = 1'b0, test_req = 1'b0, fuse = 1'b0, alarm = 1'b0, secure = 1'b0, tamper = 1'b0;
   logic go = 1'b0, wr = 1'b0, fe = 1'b0, bad = 1'b0, rwr = 1'b0, rrd = 1'b0, ecc = 1'b0, dread = 1'b0;
   logic [1:0] seg = 2'h0;
   logic [15:0] addr = 16'h0000;
   logic [3:0] ra = 4'h0;
   logic [7:0] rwd = 8'h00, nv_cnt = 8'h05, rdata, cnt_o;
   logic a_valid, a_write, a_fetch, a_par, w_par, grant, ok, sres, cnt_we, dead, test_fw;
   logic [1:0] a_seg, mode;
   logic [2:0] cause;
   logic [15:0] a_addr, maddr;
   logic [31:0] a_wdata, bus_word, mwd, pw;
   int err_count = 0, total_checks = 0;
   initial forever #5 mclk_i = ~mclk_i;
   sfm_cpu_model cpu (.mclk_i(mclk_i), .go_i(go), .write_i(wr), .fetch_i(fe), .seg_i(seg), .addr_i(addr),
      .bad_par_i(bad), .acc_valid_o(a_valid), .acc_write_o(a_write), .acc_fetch_o(a_fetch), .acc_addr_o(a_addr),
      .acc_addr_par_o(a_par), .acc_wdata_o(a_wdata), .acc_code_seg_o(a_seg), .bus_word_o(bus_word),
      .bus_word_par_o(w_par));
   sfm_monitor dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .test_req_i(test_req), .fuse_delivered_i(fuse),
      .nv_errcnt_i(nv_cnt), .sensor_alarm_i(alarm), .sensor_secure_i(secure), .tamper_i(tamper),
      .nvm_ecc_err_i(ecc), .nvm_dread_mismatch_i(dread), .acc_valid_i(a_valid), .acc_write_i(a_write),
      .acc_fetch_i(a_fetch), .acc_addr_i(a_addr), .acc_addr_par_i(a_par), .acc_wdata_i(a_wdata),
      .acc_code_seg_i(a_seg), .bus_word_i(bus_word), .bus_word_par_i(w_par), .reg_addr_i(ra), .reg_wdata_i(rwd),
      .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rdata), .mode_o(mode), .test_fw_o(test_fw), .acc_grant_o(grant),
      .mem_addr_o(maddr), .mem_wdata_o(mwd), .word_plain_o(pw), .word_ok_o(ok), .sys_reset_o(sres), .nv_errcnt_o(cnt_o),
      .nv_errcnt_we_o(cnt_we), .dead_o(dead), .cause_o(cause));
   // the bench stands in for the non-volatile counter store
   always @(posedge mclk_i) if (cnt_we === 1'b1) nv_cnt <= cnt_o;
   task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_flag(input string what, input logic exp, input logic got);
      chk_val(what, {15'h0000, exp}, {15'h0000, got});
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic do_reset(input logic treq, input logic fz, input logic [7:0] cnt);
      @(posedge mclk_i);
      resetn_i <= 1'b0;
      test_req <= treq;
      fuse <= fz;
      nv_cnt <= cnt;
      repeat (10) @(posedge mclk_i);
      resetn_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      #1;
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      ra <= a;
      rwd <= d;
      rwr <= 1'b1;
      @(posedge mclk_i);
      rwr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge mclk_i);
      ra <= a;
      rrd <= 1'b1;
      @(posedge mclk_i);
      rrd <= 1'b0;
      #1 chk_val("register read", {8'h00, exp}, {8'h00, rdata});
   endtask
   task automatic access(input logic [15:0] a, input logic w, input logic [1:0] s, input logic b);
      @(posedge mclk_i);
      go <= 1'b1;
      addr <= a;
      wr <= w;
      seg <= s;
      bad <= b;
      @(posedge mclk_i);
      go <= 1'b0;
      @(posedge mclk_i);
      #1;
   endtask
   // counted given as x when the count effect is left open
   task automatic wait_rst(input logic [2:0] c, input logic counted);
      int n;
      n = 1;
      chk_flag("reset raised", 1'b1, sres);
      chk_val("cause", 16'(c), 16'(cause));
      if (counted !== 1'bx) chk_flag("count strobe", counted, cnt_we);
      while (sres === 1'b1 && n < 40) begin
         @(posedge mclk_i);
         #1 if (sres === 1'b1) n++;
      end
      chk_val("reset length", 16'(RST_PULSE_LEN), 16'(n));
      repeat (2) @(posedge mclk_i);
   endtask
   initial begin
      repeat (20000) @(posedge mclk_i);
      err_count++;
      conclude();
   end
   initial begin
      logic [1:0] s;
      logic [15:0] a0;
      logic [31:0] ct;
      void'($urandom(91079));
      do_reset(1'b1, 1'b0, 8'h05);
      chk_flag("test firmware", 1'b1, test_fw);
      chk_val("mode", 16'(MODE_PRIV), 16'(mode));
      do_reset(1'b1, 1'b1, 8'h05);
      chk_flag("test firmware", 1'b0, test_fw);
      chk_val("mode", 16'(MODE_USER), 16'(mode));
      reg_wr(REG_MMU_OPEN, 8'h0F);
      reg_rd(REG_MMU_OPEN, MMU_OPEN_RST);
      access(16'($urandom & 32'h07FF), 1'b1, 2'h0, 1'b0);
      wait_rst(CAUSE_ACCESS, 1'b0);
      reg_rd(REG_FUSE, 8'h00);
      wait_rst(CAUSE_SFR, 1'b1);
      $display("test boot modes done");
      do_reset(1'b0, 1'b0, 8'h05);
      chk_flag("test firmware", 1'b0, test_fw);
      reg_rd(REG_MMU_OPEN, MMU_OPEN_RST);
      reg_rd(REG_FIREWALL, FIREWALL_RST);
      reg_rd(REG_ERRCNT, 8'h05);
      s = 2'($urandom);
      access(16'h8000 | 16'($urandom & 32'h3FFF), 1'b0, s, 1'b0);
      wait_rst(CAUSE_ACCESS, 1'b0);
      do_reset(1'b0, 1'b0, 8'h05);
      reg_wr(REG_MMU_OPEN, 8'h01 << s);
      fe <= 1'b1;
      access(16'h8010, 1'b1, s, 1'b0);
      fe <= 1'b0;
      wait_rst(CAUSE_ACCESS, 1'b0);
      reg_wr(REG_MMU_OPEN, 8'h01 << s);
      access(16'h8010, 1'b1, s, 1'b0);
      ct = mwd;
      a0 = maddr;
      access(16'h8010, 1'b0, s, 1'b0);
      chk_flag("grant", 1'b1, grant);
      chk_flag("word ok", 1'b1, ok);
      chk_val("cipher high", 16'hFFFF, 16'((ct ^ pw) >> 16));
      chk_val("cipher low", 16'hFFFF, 16'(ct ^ pw));
      access(16'h8011, 1'b0, s, 1'b0);
      chk_flag("scramble distinct", 1'b1, maddr != a0);
      reg_wr(REG_MMU_OPEN, 8'h0F);
      access(16'h1000, 1'b0, 2'h0, 1'b1);
      wait_rst(CAUSE_INTEGRITY, 1'b1);
      reg_rd(REG_ERRCNT, 8'h04);
      reg_rd(REG_MMU_OPEN, MMU_OPEN_RST);
      access(16'hC000, 1'b0, 2'h0, 1'b0);
      wait_rst(CAUSE_RANGE, 1'b0);
      reg_rd(REG_ERRCNT, 8'h04);
      reg_wr(REG_SWRESET, 8'h01);
      #1 wait_rst(CAUSE_SOFT, 1'b0);
      for (int i = 0; i < 8; i++) begin
         access(i == 0 ? 16'h7FFF : 16'($urandom & 32'h7FFF), 1'($urandom), 2'($urandom), 1'b0);
         chk_flag("grant", 1'b1, grant);
      end
      $display("test access checks done");
      for (int k = 0; k < 5; k++) begin
         @(posedge mclk_i);
         alarm <= (k < 2);
         secure <= (k == 0);
         tamper <= (k == 2);
         ecc <= (k == 3);
         dread <= (k == 4);
         @(posedge mclk_i);
         alarm <= 1'b0;
         secure <= 1'b0;
         tamper <= 1'b0;
         ecc <= 1'b0;
         dread <= 1'b0;
         #1 wait_rst(k < 2 ? CAUSE_SENSOR : CAUSE_INTEGRITY, k % 2 == 0);
      end
      reg_rd(REG_ERRCNT, 8'h01);
      reg_rd(4'h6, 8'h00);
      wait_rst(CAUSE_SFR, 1'b1);
      access(16'h0200, 1'b0, 2'h1, 1'b1);
      repeat (30) @(posedge mclk_i);
      #1 chk_flag("dead", 1'b1, dead);
      chk_val("nv counter", 16'h0000, {8'h00, nv_cnt});
      access(16'h0100, 1'b0, 2'h0, 1'b0);
      chk_flag("grant", 1'b0, grant);
      do_reset(1'b0, 1'b0, 8'h00);
      #1 chk_flag("dead", 1'b1, dead);
      $display("test faults and counter done");
      conclude();
   end
endmodule
